/* pvs_pkg.sv */
// constants and types for the pcm voice serial port
package pvs_pkg;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_HZ    = 10_000_000;
    localparam int SYNC_HZ    = 8_000;
    localparam int BCLK_HALF  = 4;
    localparam int FRAME_BITS = CORE_HZ / (2 * BCLK_HALF * SYNC_HZ);
    localparam int LONG_BITS  = 8;
    // ------------------------------------------------------------
    // framing
    // ------------------------------------------------------------
    localparam int NUM_SLOTS  = 4;
    localparam int MAX_LINKS  = 3;
    localparam logic [4:0] W_COMP  = 5'h08;
    localparam logic [4:0] W_LIN13 = 5'h0d;
    localparam logic [4:0] W_LIN16 = 5'h10;
    localparam logic [4:0] W_FULL  = 5'h10;
    localparam logic [3:0] SEL_ALL = 4'hf;
    localparam int BUF_DEPTH  = 2;

    typedef enum logic [1:0] {
        PVS_LONG,
        PVS_SHORT,
        PVS_GCI
    } pvs_frame_e;

    typedef enum logic [1:0] {
        PVS_LIN13,
        PVS_LIN16,
        PVS_MULAW,
        PVS_ALAW
    } pvs_samp_e;
endpackage

/* pvs_port.sv */
// pcm voice serial port: master/slave framing, slots and word buffers
`timescale 1ns/100ps
// What this block does
// - carries up to three voice links, one slot each
// - master drives bit clock and frame sync
// - slave takes bit clock and sync from outside
// - long, short or gci framing selectable
// - 13/16-bit linear or 8-bit companded words
// - up to three of first four slots used
// - long sync rising edge starts the word
// - master long sync high eight bit clocks
// - slave long sync one bit to half frame
// - sample input on fall, launch on rise
// - output released in lsb fall or next rise
// - short sync falling edge starts, one bit wide
// - frame sync repeats at 8 kHz

// ------------------------------------------------------------
// two-entry style buffer, head held in a flop
// ------------------------------------------------------------
module pvs_buf
    import pvs_pkg::*;
#(
    parameter int W     = 16,
    parameter int DEPTH = BUF_DEPTH
) (
    // clocking
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    input  wire logic         clk_en,
    // fill side
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    // drain side
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);
    logic [W-1:0]     d_q [DEPTH];
    logic [W-1:0]     d_d [DEPTH];
    logic [DEPTH-1:0] v_q;
    logic [DEPTH-1:0] v_d;

    always_comb begin
        logic placed;
        placed = 1'b0;
        d_d = d_q;
        v_d = v_q;
        // shift on pop so the head is always entry zero
        if (v_q[0] && out_ready) begin
            for (int i = 0; i < DEPTH - 1; i++) begin
                d_d[i] = d_q[i+1];
                v_d[i] = v_q[i+1];
            end
            v_d[DEPTH-1] = 1'b0;
        end
        // full is judged before the pop: costs one cycle, no comb path
        if (in_valid && !v_q[DEPTH-1]) begin
            for (int i = 0; i < DEPTH; i++) begin
                if (!placed && !v_d[i]) begin
                    d_d[i] = in_data;
                    v_d[i] = 1'b1;
                    placed = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            v_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                d_q[i] <= '0;
            end
        end else if (clk_en) begin
            v_q <= v_d;
            d_q <= d_d;
        end
    end

    assign out_data  = d_q[0];
    assign out_valid = v_q[0];
    assign in_ready  = !v_q[DEPTH-1];
endmodule

// ------------------------------------------------------------
// port top
// ------------------------------------------------------------
module pvs_port
    import pvs_pkg::*;
#(
    parameter int HALF   = BCLK_HALF,
    parameter int FRAMEB = FRAME_BITS
) (
    // clocking
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic        clk_en,
    // configuration
    input  wire logic        master,
    input  wire logic [1:0]  frame_fmt,
    input  wire logic [1:0]  samp_fmt,
    input  wire logic [3:0]  slot_sel,
    input  wire logic        tz_early,
    // serial pins
    input  wire logic        bclk_i,
    output logic             bclk_o,
    output logic             bclk_oe,
    input  wire logic        sync_i,
    output logic             sync_o,
    output logic             sync_oe,
    input  wire logic        din_i,
    output logic             dout_o,
    output logic             dout_oe,
    // transmit words
    input  wire logic [15:0] tx_data,
    input  wire logic        tx_valid,
    output logic             tx_ready,
    // receive words
    output logic [15:0]      rx_data,
    output logic [1:0]       rx_slot,
    output logic             rx_valid,
    input  wire logic        rx_ready,
    output logic             rx_lost
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] wid(input logic [1:0] f);
        case (f)
            PVS_LIN13: wid = W_LIN13;
            PVS_LIN16: wid = W_LIN16;
            default:   wid = W_COMP;
        endcase
    endfunction

    // up to three of the first four slots
    // a fourth slot is dropped so at most three links run
    function automatic logic used(input logic [3:0] m,
                                  input logic [1:0] s);
        logic [3:0] e;
        e = (m == SEL_ALL) ? 4'h7 : m;
        used = e[s];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic        bclk_s1, bclk_s2, sync_s1, sync_s2, din_s1, din_s2;
    logic [7:0]  div_q,  div_d;
    logic [15:0] fb_q,   fb_d;
    logic        bclk_q, bclk_d, sync_q, sync_d, mst_q;
    logic        bclk_p, sync_p;
    logic        act_q,  act_d, first_q, first_d, arm_q, arm_d;
    logic [1:0]  slot_q, slot_d;
    logic [4:0]  bit_q,  bit_d;
    logic [15:0] txs_q,  txs_d, rxs_q, rxs_d;
    logic        dout_q, dout_d, doe_q, doe_d, lost_d;
    logic        bclk_v, sync_v, rise, fall, lstart, sstart;
    logic [4:0]  w;
    logic [15:0] tx_hd;
    logic        tx_hv, tx_pop, rx_push, rx_in_rdy;
    logic [17:0] rx_word;
    logic [17:0] rx_out;

    // ------------------------------------------------------------
    // bit clock and sync generator
    // ------------------------------------------------------------
    always_comb begin
        div_d  = div_q;
        bclk_d = bclk_q;
        fb_d   = fb_q;
        sync_d = sync_q;
        if (master) begin
            div_d = div_q + 8'h01;
            if (div_q == 8'(HALF - 1)) begin
                div_d  = '0;
                bclk_d = !bclk_q;
                if (!bclk_q) begin
                    fb_d = (fb_q == 16'(FRAMEB - 1)) ? '0 : fb_q + 16'h1;
                    case (frame_fmt)
                        PVS_LONG:  sync_d = fb_d < 16'(LONG_BITS);
                        PVS_SHORT: sync_d = fb_d == 16'(FRAMEB - 1);
                        default:   sync_d = fb_d == '0;
                    endcase
                end
            end
        end else begin
            div_d  = '0;
            bclk_d = 1'b0;
            fb_d   = 16'(FRAMEB - 1);
            sync_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // framing, shifting and slots
    // ------------------------------------------------------------
    // slave reads the synchronised pins
    assign bclk_v  = mst_q ? bclk_q : bclk_s2;
    assign sync_v  = mst_q ? sync_q : sync_s2;
    assign rise    = bclk_v && !bclk_p;
    assign fall    = !bclk_v && bclk_p;
    assign w       = wid(samp_fmt);
    // long/gci start on sync rise; width not checked
    assign lstart  = (frame_fmt != PVS_SHORT) && sync_v && !sync_p;
    assign sstart  = (frame_fmt == PVS_SHORT) && arm_q && rise;
    assign rx_word = {slot_q, rxs_q[14:0], din_s2};

    always_comb begin
        act_d   = act_q;
        first_d = first_q;
        arm_d   = arm_q;
        slot_d  = slot_q;
        bit_d   = bit_q;
        txs_d   = txs_q;
        rxs_d   = rxs_q;
        dout_d  = dout_q;
        doe_d   = doe_q;
        tx_pop  = 1'b0;
        rx_push = 1'b0;
        lost_d  = 1'b0;
        if (lstart || sstart || (rise && act_q && !first_q &&
                                 bit_q == w - 5'h01 && slot_q != 2'h3)) begin
            // next slot follows at once, msb first
            act_d   = 1'b1;
            first_d = lstart;
            arm_d   = 1'b0;
            slot_d  = (lstart || sstart) ? 2'h0 : slot_q + 2'h1;
            bit_d   = '0;
            rxs_d   = '0;
            if (used(slot_sel, slot_d)) begin
                // word left aligned to the sample width
                txs_d  = tx_hv ? tx_hd << (W_FULL - w) : '0;
                tx_pop = tx_hv;
                dout_d = txs_d[15];
                doe_d  = 1'b1;
            end else begin
                dout_d = 1'b0;
                doe_d  = 1'b0;
            end
        end else if (rise && act_q && !first_q) begin
            if (bit_q == w - 5'h01) begin
                act_d  = 1'b0;
                doe_d  = 1'b0;
                dout_d = 1'b0;
            end else begin
                bit_d  = bit_q + 5'h01;
                txs_d  = txs_q << 1;
                dout_d = txs_q[14];
            end
        end else if (rise) begin
            // late release on the rise after the lsb
            if (!act_q) begin
                doe_d = 1'b0;
            end
        end
        if (fall) begin
            first_d = 1'b0;
            // short pulse seen on a fall arms the start
            arm_d = (frame_fmt == PVS_SHORT) && sync_v;
            // input ignored unless the slot is selected
            if (act_q && used(slot_sel, slot_q)) begin
                rxs_d = {rxs_q[14:0], din_s2};
                if (bit_q == w - 5'h01) begin
                    rx_push = 1'b1;
                    lost_d  = !rx_in_rdy;
                    if (tz_early) begin
                        doe_d = 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bclk_s1 <= 1'b0;
            bclk_s2 <= 1'b0;
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
            div_q   <= '0;
            // start on the wrap so the first frame is whole
            fb_q    <= 16'(FRAMEB - 1);
            bclk_q  <= 1'b0;
            sync_q  <= 1'b0;
            mst_q   <= 1'b0;
            bclk_p  <= 1'b0;
            sync_p  <= 1'b0;
            act_q   <= 1'b0;
            first_q <= 1'b0;
            arm_q   <= 1'b0;
            slot_q  <= '0;
            bit_q   <= '0;
            txs_q   <= '0;
            rxs_q   <= '0;
            dout_q  <= 1'b0;
            doe_q   <= 1'b0;
            rx_lost <= 1'b0;
        end else if (clk_en) begin
            // pins cross in two flops before use
            bclk_s1 <= bclk_i;
            bclk_s2 <= bclk_s1;
            sync_s1 <= sync_i;
            sync_s2 <= sync_s1;
            din_s1  <= din_i;
            din_s2  <= din_s1;
            div_q   <= div_d;
            fb_q    <= fb_d;
            bclk_q  <= bclk_d;
            sync_q  <= sync_d;
            mst_q   <= master;
            bclk_p  <= bclk_v;
            sync_p  <= sync_v;
            act_q   <= act_d;
            first_q <= first_d;
            arm_q   <= arm_d;
            slot_q  <= slot_d;
            bit_q   <= bit_d;
            txs_q   <= txs_d;
            rxs_q   <= rxs_d;
            dout_q  <= dout_d;
            doe_q   <= doe_d;
            rx_lost <= lost_d;
        end
    end

    // ------------------------------------------------------------
    // word buffers
    // ------------------------------------------------------------
    // an empty transmit buffer sends zeros rather than stalling the link
    pvs_buf #(.W(16), .DEPTH(BUF_DEPTH)) u_txb (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_data   (tx_data),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .out_data  (tx_hd),
        .out_valid (tx_hv),
        .out_ready (tx_pop)
    );

    pvs_buf #(.W(18), .DEPTH(BUF_DEPTH)) u_rxb (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .clk_en    (clk_en),
        .in_data   (rx_word),
        .in_valid  (rx_push),
        .in_ready  (rx_in_rdy),
        .out_data  (rx_out),
        .out_valid (rx_valid),
        .out_ready (rx_ready)
    );

    assign rx_data = rx_out[15:0];
    assign rx_slot = rx_out[17:16];
    assign bclk_o  = bclk_q;
    assign sync_o  = sync_q;
    assign bclk_oe = mst_q;
    assign sync_oe = mst_q;
    assign dout_o  = dout_q;
    assign dout_oe = doe_q;
endmodule

/* pvs_port_assertions.sv */
// assertion checker for the pcm voice serial port
`timescale 1ns/100ps
module pvs_port_checker #(
    parameter int HALF   = 4,
    parameter int FRAMEB = 70
) (
    // clocking
    input wire logic       core_clk,
    input wire logic       rst_b,
    // configuration
    input wire logic       master,
    input wire logic [1:0] frame_fmt,
    input wire logic       tz_early,
    // serial pins
    input wire logic       bclk_o,
    input wire logic       bclk_oe,
    input wire logic       sync_o,
    input wire logic       sync_oe,
    input wire logic       dout_oe
);
    logic [15:0] hi_q, hi_d, per_q, per_d;
    logic        sync_q, seen_q, seen_d;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // ----------
    // sync width and period counters
    // ----------
    always_comb begin
        hi_d   = sync_o ? hi_q + 16'h0001 : 16'h0000;
        per_d  = (sync_o && !sync_q) ? 16'h0000 : per_q + 16'h0001;
        seen_d = seen_q | (sync_o & ~sync_q);
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            {hi_q, per_q, sync_q, seen_q} <= '0;
        end else begin
            {hi_q, per_q, sync_q, seen_q} <= {hi_d, per_d, sync_o, seen_d};
        end
    end
    // ----------
    // properties
    // ----------
    AST_PIN_DIR: assert property (
        $past(rst_b) |-> bclk_oe == $past(master) && sync_oe == $past(master))
        else $error("pin drive not following master");
    AST_BCLK_HALF: assert property (
        bclk_oe && $rose(bclk_o) |=> bclk_o [*3] ##1 !bclk_o)
        else $error("bit clock high phase wrong");
    AST_LONG_SYNC: assert property (
        $fell(sync_o) && sync_oe && frame_fmt == 2'h0
        |-> hi_q == 16'(16 * HALF))
        else $error("long sync not eight bits");
    AST_SHORT_SYNC: assert property (
        $fell(sync_o) && sync_oe && frame_fmt != 2'h0
        |-> hi_q == 16'(2 * HALF))
        else $error("short or gci sync not one bit");
    AST_FRAME_RATE: assert property (
        sync_o && !sync_q && seen_q && sync_oe
        |-> per_q == 16'(2 * HALF * FRAMEB - 1))
        else $error("frame period wrong");
    AST_LAUNCH_RISE: assert property (
        $rose(dout_oe) && bclk_oe |-> bclk_o)
        else $error("word launched off the rise");
    AST_TZ_EARLY: assert property (
        $fell(dout_oe) && bclk_oe && tz_early |-> !bclk_o)
        else $error("early release not in low phase");
    AST_TZ_LATE: assert property (
        $fell(dout_oe) && bclk_oe && !tz_early |-> bclk_o)
        else $error("late release not in high phase");
endmodule
bind pvs_port pvs_port_checker #(.HALF(HALF), .FRAMEB(FRAMEB)) chk_u (
    .core_clk(core_clk), .rst_b(rst_b), .master(master),
    .frame_fmt(frame_fmt), .tz_early(tz_early), .bclk_o(bclk_o),
    .bclk_oe(bclk_oe), .sync_o(sync_o), .sync_oe(sync_oe),
    .dout_oe(dout_oe));

/* pvs_codec_model.sv */
// codec-side partner for the pcm voice serial port
`timescale 1ns/100ps
module pvs_codec_model #(
    parameter int FR = 70
) (
    // control
    input wire logic        hold,
    input wire logic [1:0]  fmt,
    input wire logic [4:0]  w,
    input wire logic [15:0] pat,
    // device pins
    input wire logic        bclk_o,
    input wire logic        bclk_oe,
    input wire logic        sync_o,
    input wire logic        sync_oe,
    input wire logic        dout_o,
    input wire logic        dout_oe,
    // resolved lines
    output logic            bclk,
    output logic            sync,
    output logic            din,
    output logic [15:0]     got
);
    logic clk_m  = 1'b0;
    logic sync_m = 1'b0;
    logic s_rise = 1'b0;
    logic s_fall = 1'b0;
    int   fc     = 0;
    int   bc     = 99;
    initial din = 1'b0;
    initial got = 16'h0000;
    // free-running 800 ns clock, frames aligned to reset release
    always #400 clk_m = ~clk_m;
    assign bclk = bclk_oe ? bclk_o : clk_m;
    assign sync = sync_oe ? sync_o : sync_m;
    always @(posedge clk_m) begin
        fc = hold ? FR - 2 : (fc == FR - 1 ? 0 : fc + 1);
        // long sync four bits, short one
        sync_m <= !hold && (fmt == 2'h1 ? fc == FR - 1 : fc < 4);
    end
    always @(posedge bclk) begin
        #1;
        if (fmt == 2'h1 ? s_fall : (sync && !s_rise)) begin
            bc = 0;
        end else if (bc < 99) begin
            bc = bc + 1;
        end
        s_rise = sync;
        // idle line keeps changing so stale bits never match
        din = (bc < 4 * w) ? pat[w - 1 - bc % w] : ~din;
    end
    // capture clear of both launch points
    always @(negedge bclk) begin
        s_fall = sync;
        #(bclk_oe ? 50 : 150);
        if (dout_oe) got = {got[14:0], dout_o};
    end
endmodule

/* pvs_port_test.sv */
// self-checking bench for the pcm voice serial port
`timescale 1ns/100ps
`define CHECK(nm, seen, exp) begin comparisons++; if ((seen) !== (exp)) \
    begin n_mismatch++; \
    $display("ERROR %s expected %h seen %h", nm, exp, seen); end end
module pvs_port_test
    import pvs_pkg::*;
;
    logic        core_clk = 1'b0, rst_b = 1'b0, master = 1'b1;
    logic        tz_early = 1'b0, tx_valid = 1'b0, rx_ready = 1'b0;
    logic [1:0]  frame_fmt = 2'h0, samp_fmt = 2'h0, rx_slot;
    logic [3:0]  slot_sel = 4'h1;
    logic [4:0]  w = 5'h08;
    logic [15:0] tx_data = 16'h0000, pat = 16'h0000, msk = 16'h00ff;
    logic [15:0] rx_data, got;
    logic        bclk_o, bclk_oe, sync_o, sync_oe, dout_o, dout_oe;
    logic        tx_ready, rx_valid, rx_lost, bclk, sync, din;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    always #50 core_clk = ~core_clk;
    pvs_port #(.HALF(4), .FRAMEB(70)) dut_u (
        .core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1),
        .master(master), .frame_fmt(frame_fmt), .samp_fmt(samp_fmt),
        .slot_sel(slot_sel), .tz_early(tz_early),
        .bclk_i(bclk), .bclk_o(bclk_o), .bclk_oe(bclk_oe),
        .sync_i(sync), .sync_o(sync_o), .sync_oe(sync_oe),
        .din_i(din), .dout_o(dout_o), .dout_oe(dout_oe),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .rx_data(rx_data), .rx_slot(rx_slot), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_lost(rx_lost));
    pvs_codec_model #(.FR(70)) codec_u (
        .hold(!rst_b), .fmt(frame_fmt), .w(w), .pat(pat),
        .bclk_o(bclk_o), .bclk_oe(bclk_oe), .sync_o(sync_o),
        .sync_oe(sync_oe), .dout_o(dout_o), .dout_oe(dout_oe),
        .bclk(bclk), .sync(sync), .din(din), .got(got));
    // ----------
    // tasks
    // ----------
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #5;
    endtask
    // first word of a run may carry zeros, so its dout is skipped
    task automatic get_rx(input logic [1:0] s, input bit tx_chk);
        int t;
        t = 0;
        while (rx_valid !== 1'b1 && t < 3000) begin
            tick(1);
            t++;
        end
        `CHECK("rx_valid", rx_valid, 1'b1)
        `CHECK("rx_data", rx_data, pat & msk)
        `CHECK("rx_slot", rx_slot, s)
        if (tx_chk) `CHECK("dout", got & msk, tx_data & msk)
        rx_ready = 1'b1;
        tick(1);
        rx_ready = 1'b0;
    endtask
    task automatic run_case(input logic m, input logic [1:0] ff, sf,
                            input logic [3:0] sel, input logic tz,
                            input logic [15:0] tw, input bit st);
        logic [1:0] sl[$];
        int t;
        for (int i = 0; i < 3 || (i == 3 && sel != SEL_ALL); i++) begin
            if (sel[i]) sl.push_back(2'(i));
        end
        rst_b = 1'b0;
        tx_valid = 1'b0;
        {master, frame_fmt, samp_fmt, slot_sel, tz_early} = {m, ff, sf, sel, tz};
        w = sf[1] ? W_COMP : (sf[0] ? W_LIN16 : W_LIN13);
        msk = 16'hffff >> (5'h10 - w);
        tx_data = tw;
        pat = ~tw ^ 16'h0f3c;
        tick(5);
        rst_b = 1'b1;
        tx_valid = 1'b1;
        tick(2);
        `CHECK("tx_ready", tx_ready, 1'b0)
        if (st) begin
            t = 0;
            while (rx_lost !== 1'b1 && t < 3000) begin
                tick(1);
                t++;
            end
            `CHECK("rx_lost", rx_lost, 1'b1)
            get_rx(sl[0], 1'b0);
            get_rx(sl[1], 1'b0);
            `CHECK("rx_empty", rx_valid, 1'b0)
        end else begin
            for (int k = 0; k < 3; k++) get_rx(sl[k % sl.size()], k > 0);
        end
        tx_valid = 1'b0;
    endtask
    // ----------
    // run and watchdog
    // ----------
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        run_case(1'b1, 2'h0, 2'h2, 4'h1, 1'b1, 16'h005a, 1'b0);
        run_case(1'b1, 2'h1, 2'h1, 4'h2, 1'b0, 16'hbeef, 1'b0);
        run_case(1'b1, 2'h2, 2'h0, 4'h5, 1'b1, 16'h1a5c, 1'b0);
        run_case(1'b0, 2'h0, 2'h3, 4'hf, 1'b0, 16'h00c3, 1'b1);
        run_case(1'b0, 2'h1, 2'h1, 4'h8, 1'b1, 16'h8421, 1'b0);
        report_and_stop();
    end
endmodule
